/* File: bcr_regs.svh */
// Register offsets, field positions and timing figures of the buck
// configuration and backup register bank.
// Assumes a byte-wide register port with an 8-bit address.
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH

`define BCR_OFF_SCR_A    8'h00
`define BCR_OFF_SCR_B    8'h01
`define BCR_OFF_SCR_C    8'h02
`define BCR_OFF_SCR_D    8'h03
`define BCR_OFF_A_RUN    8'h04
`define BCR_OFF_A_STBY   8'h05
`define BCR_OFF_A_SLP    8'h06
`define BCR_OFF_A_MODE   8'h07
`define BCR_OFF_A_CONF   8'h08
`define BCR_OFF_B_RUN    8'h09
`define BCR_OFF_B_STBY   8'h0a
`define BCR_OFF_B_SLP    8'h0b
`define BCR_OFF_B_MODE   8'h0c

`define BCR_MASK_VCODE   8'h1f
`define BCR_MASK_MODE    8'h2f
`define BCR_MASK_CONF    8'h7d

`define BCR_VCODE_HI     4
`define BCR_OMODE_BIT    5
`define BCR_SMODE_HI     3
`define BCR_DVS_BIT      6
`define BCR_PHASE_HI     5
`define BCR_PHASE_LO     4
`define BCR_FREQ_HI      3
`define BCR_FREQ_LO      2
`define BCR_ILIM_BIT     0

`define BCR_PS_IN_RUN    2'h0
`define BCR_PS_IN_STBY   2'h1

`define BCR_CLK_NS       20
`define BCR_STEP_FAST_NS 2000
`define BCR_STEP_SLOW_NS 4000
`define BCR_STEP_FAST_CYC (`BCR_STEP_FAST_NS / `BCR_CLK_NS)
`define BCR_STEP_SLOW_CYC (`BCR_STEP_SLOW_NS / `BCR_CLK_NS)

`endif

/* File: bcr_pkg.sv */
// Types of the buck configuration and backup register bank.
// Used together with bcr_regs.svh for offsets and field positions.
package bcr_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bcr_bus_t;

	typedef struct packed {
		logic [7:0] a_run;
		logic [7:0] a_stby;
		logic [7:0] a_slp;
		logic [7:0] a_mode;
		logic [7:0] a_conf;
		logic [7:0] b_run;
		logic [7:0] b_stby;
		logic [7:0] b_slp;
		logic [7:0] b_mode;
	} bcr_cfg_t;

	typedef struct packed {
		logic [4:0] vcode;
		logic       on;
		logic [3:0] mode;
	} bcr_chan_t;

	typedef struct packed {
		logic       step_slow;
		logic [1:0] phase;
		logic [1:0] freq;
		logic       ilim;
	} bcr_conf_t;

	typedef enum logic [1:0] {
		BCR_LD_OTP = 2'b01,
		BCR_LD_RUN = 2'b10
	} bcr_ld_t;

	typedef enum logic [2:0] {
		BCR_PS_RUN   = 3'b001,
		BCR_PS_STBY  = 3'b010,
		BCR_PS_SLEEP = 3'b100
	} bcr_ps_t;

	typedef struct packed {
		bcr_ld_t    ld;
		logic [1:0] ps_m;
		logic [1:0] ps_s;
		bcr_ps_t    ps;
		bcr_cfg_t   cfg;
		logic [7:0] rd;
		logic [4:0] a_v;
		logic [7:0] a_cnt;
		logic [4:0] b_v;
		logic       a_on;
		logic       b_on;
	} bcr_state_t;

endpackage

/* File: bcr_bank.sv */
// Buck channel configuration registers and coin-cell backed scratch
// registers, reached over a simple strobe register port.
// Assumes a byte-wide master that never drives both strobes at once,
// an OTP image that is valid at the first clock edge after rst falls, and a power state
// input that comes from another clock domain.
// Notes on behaviour
// - Four 8-bit scratch registers survive main power loss.
// - Only coin-cell reset clears the scratch registers.
// - Channel A run voltage code in bits 4:0.
// - Channel A standby code applied in standby.
// - Channel A sleep code applied in sleep.
// - Channel B run voltage code in bits 4:0.
// - Channel B standby and sleep codes applied.
// - Buck registers accessible in every power state.
// - Buck registers load defaults from OTP image.
// - Channel A bit 5 picks off or sleep.
// - Channel B bit 5 picks off or sleep.
// - Channel A switching mode from bits 3:0.
// - Channel B switching mode from bits 3:0.
// - Channel A step rate: 2 or 4 us.
// - Channel A bits 5:4 select clock phase.
// - Channel A bits 3:2 select switching frequency.
// - Channel A bit 0 selects current limit.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bcr_regs.svh"

module bcr_bank (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              coin_cell_por_n,
	input  wire bcr_pkg::bcr_bus_t bus,
	output logic [7:0]             rd_data,
	input  wire bcr_pkg::bcr_cfg_t otp,
	input  wire logic [1:0]        pwr_state_in,
	output bcr_pkg::bcr_chan_t     chan_a,
	output bcr_pkg::bcr_chan_t     chan_b,
	output bcr_pkg::bcr_conf_t     chan_a_conf
);
	import bcr_pkg::*;

	bcr_state_t st_r;
	bcr_state_t st_nxt;
	logic [7:0] scr_r [4];
	logic [7:0] rd_val;
	logic [4:0] tgt_a;
	logic [4:0] tgt_b;
	logic [7:0] step_a;
	logic       scr_hit;

	function automatic logic [7:0] fmask(input logic [7:0] v,
	                                     input logic [7:0] m);
		return v & m;
	endfunction

	function automatic logic [4:0] sel_code(input bcr_ps_t ps,
	                                        input logic [7:0] run,
	                                        input logic [7:0] stby,
	                                        input logic [7:0] slp);
		case (ps)
			BCR_PS_STBY:  return stby[`BCR_VCODE_HI:0];
			BCR_PS_SLEEP: return slp[`BCR_VCODE_HI:0];
			default:      return run[`BCR_VCODE_HI:0];
		endcase
	endfunction

	function automatic bcr_ps_t ps_decode(input logic [1:0] raw);
		case (raw)
			`BCR_PS_IN_RUN:  return BCR_PS_RUN;
			`BCR_PS_IN_STBY: return BCR_PS_STBY;
			default:         return BCR_PS_SLEEP;
		endcase
	endfunction

	function automatic bcr_cfg_t mask_cfg(input bcr_cfg_t c);
		bcr_cfg_t m;
		m        = c;
		m.a_run  = fmask(c.a_run, `BCR_MASK_VCODE);
		m.a_stby = fmask(c.a_stby, `BCR_MASK_VCODE);
		m.a_slp  = fmask(c.a_slp, `BCR_MASK_VCODE);
		m.a_mode = fmask(c.a_mode, `BCR_MASK_MODE);
		m.a_conf = fmask(c.a_conf, `BCR_MASK_CONF);
		m.b_run  = fmask(c.b_run, `BCR_MASK_VCODE);
		m.b_stby = fmask(c.b_stby, `BCR_MASK_VCODE);
		m.b_slp  = fmask(c.b_slp, `BCR_MASK_VCODE);
		m.b_mode = fmask(c.b_mode, `BCR_MASK_MODE);
		return m;
	endfunction

	assign scr_hit = (bus.addr <= `BCR_OFF_SCR_D);

	// Scratch storage sits in the coin-cell domain: the main reset is not
	// wired here, so a main power cycle leaves the contents alone.
	always_ff @(posedge mclk or negedge coin_cell_por_n) begin
		if (!coin_cell_por_n) begin
			for (int i = 0; i < 4; i++) begin
				scr_r[i] <= '0;
			end
		end else if (bus.wr && scr_hit) begin
			scr_r[bus.addr[1:0]] <= bus.wdata;
		end
	end

	always_comb begin
		case (bus.addr)
			`BCR_OFF_SCR_A,
			`BCR_OFF_SCR_B,
			`BCR_OFF_SCR_C,
			`BCR_OFF_SCR_D:  rd_val = scr_r[bus.addr[1:0]];
			`BCR_OFF_A_RUN:  rd_val = st_r.cfg.a_run;
			`BCR_OFF_A_STBY: rd_val = st_r.cfg.a_stby;
			`BCR_OFF_A_SLP:  rd_val = st_r.cfg.a_slp;
			`BCR_OFF_A_MODE: rd_val = st_r.cfg.a_mode;
			`BCR_OFF_A_CONF: rd_val = st_r.cfg.a_conf;
			`BCR_OFF_B_RUN:  rd_val = st_r.cfg.b_run;
			`BCR_OFF_B_STBY: rd_val = st_r.cfg.b_stby;
			`BCR_OFF_B_SLP:  rd_val = st_r.cfg.b_slp;
			`BCR_OFF_B_MODE: rd_val = st_r.cfg.b_mode;
			default:         rd_val = '0;
		endcase
	end

	always_comb begin
		tgt_a = sel_code(st_r.ps, st_r.cfg.a_run, st_r.cfg.a_stby,
		                 st_r.cfg.a_slp);
		tgt_b = sel_code(st_r.ps, st_r.cfg.b_run, st_r.cfg.b_stby,
		                 st_r.cfg.b_slp);
		step_a = st_r.cfg.a_conf[`BCR_DVS_BIT] ?
		         8'(`BCR_STEP_SLOW_CYC - 1) :
		         8'(`BCR_STEP_FAST_CYC - 1);
	end

	always_comb begin
		st_nxt      = st_r;
		st_nxt.ps_m = pwr_state_in;
		st_nxt.ps_s = st_r.ps_m;
		st_nxt.ps   = ps_decode(st_r.ps_s);
		st_nxt.rd   = '0;
		case (st_r.ld)
			BCR_LD_OTP: begin
				// The OTP image is taken once, right after reset release.
				st_nxt.cfg = mask_cfg(otp);
				st_nxt.a_v = otp.a_run[`BCR_VCODE_HI:0];
				st_nxt.b_v = otp.b_run[`BCR_VCODE_HI:0];
				st_nxt.a_cnt = '0;
				st_nxt.ld  = BCR_LD_RUN;
			end
			BCR_LD_RUN: begin
				// No power-state gating on access, by design.
				if (bus.wr) begin
					case (bus.addr)
						`BCR_OFF_A_RUN: st_nxt.cfg.a_run =
							fmask(bus.wdata, `BCR_MASK_VCODE);
						`BCR_OFF_A_STBY: st_nxt.cfg.a_stby =
							fmask(bus.wdata, `BCR_MASK_VCODE);
						`BCR_OFF_A_SLP: st_nxt.cfg.a_slp =
							fmask(bus.wdata, `BCR_MASK_VCODE);
						`BCR_OFF_A_MODE: st_nxt.cfg.a_mode =
							fmask(bus.wdata, `BCR_MASK_MODE);
						`BCR_OFF_A_CONF: st_nxt.cfg.a_conf =
							fmask(bus.wdata, `BCR_MASK_CONF);
						`BCR_OFF_B_RUN: st_nxt.cfg.b_run =
							fmask(bus.wdata, `BCR_MASK_VCODE);
						`BCR_OFF_B_STBY: st_nxt.cfg.b_stby =
							fmask(bus.wdata, `BCR_MASK_VCODE);
						`BCR_OFF_B_SLP: st_nxt.cfg.b_slp =
							fmask(bus.wdata, `BCR_MASK_VCODE);
						`BCR_OFF_B_MODE: st_nxt.cfg.b_mode =
							fmask(bus.wdata, `BCR_MASK_MODE);
						default: st_nxt.cfg = st_r.cfg;
					endcase
				end
				if (bus.rd) begin
					st_nxt.rd = rd_val;
				end
				// Channel A ramps one code per step period so that the
				// output moves at the selected slew; a shortened period
				// after a rate change takes effect at once.
				if (st_r.a_v == tgt_a) begin
					st_nxt.a_cnt = step_a;
				end else if (st_r.a_cnt == '0) begin
					st_nxt.a_v = (st_r.a_v > tgt_a) ?
					             5'(st_r.a_v - 5'h01) :
					             5'(st_r.a_v + 5'h01);
					st_nxt.a_cnt = step_a;
				end else if (st_r.a_cnt > step_a) begin
					st_nxt.a_cnt = step_a;
				end else begin
					st_nxt.a_cnt = 8'(st_r.a_cnt - 8'h01);
				end
				st_nxt.b_v = tgt_b;
			end
			default: st_nxt.ld = BCR_LD_OTP;
		endcase
		st_nxt.a_on = (st_r.ps != BCR_PS_SLEEP) ||
		              st_r.cfg.a_mode[`BCR_OMODE_BIT];
		st_nxt.b_on = (st_r.ps != BCR_PS_SLEEP) ||
		              st_r.cfg.b_mode[`BCR_OMODE_BIT];
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r    <= '0;
			st_r.ld <= BCR_LD_OTP;
			st_r.ps <= BCR_PS_RUN;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data           = st_r.rd;
	assign chan_a.vcode      = st_r.a_v;
	assign chan_a.on         = st_r.a_on;
	assign chan_a.mode       = st_r.cfg.a_mode[`BCR_SMODE_HI:0];
	assign chan_b.vcode      = st_r.b_v;
	assign chan_b.on         = st_r.b_on;
	assign chan_b.mode       = st_r.cfg.b_mode[`BCR_SMODE_HI:0];
	assign chan_a_conf.step_slow = st_r.cfg.a_conf[`BCR_DVS_BIT];
	assign chan_a_conf.phase =
		st_r.cfg.a_conf[`BCR_PHASE_HI:`BCR_PHASE_LO];
	assign chan_a_conf.freq  =
		st_r.cfg.a_conf[`BCR_FREQ_HI:`BCR_FREQ_LO];
	assign chan_a_conf.ilim  = st_r.cfg.a_conf[`BCR_ILIM_BIT];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_scr_rdback;
		(bus.wr && scr_hit) ##1 (bus.rd && bus.addr == $past(bus.addr))
		|=> rd_data == $past(bus.wdata, 2);
	endproperty
	a_scr_rdback: assert property (p_scr_rdback)
		else $error("scratch read back differs from write");

	property p_scr_keep;
		@(posedge mclk) disable iff (!coin_cell_por_n)
		(rst && !bus.wr) |=> (scr_r[0] == $past(scr_r[0])) &&
		                     (scr_r[3] == $past(scr_r[3]));
	endproperty
	a_scr_keep: assert property (p_scr_keep)
		else $error("scratch changed under main reset");

	property p_otp_load;
		st_r.ld == BCR_LD_OTP |=> st_r.cfg == mask_cfg($past(otp))
		                         && st_r.ld == BCR_LD_RUN;
	endproperty
	a_otp_load: assert property (p_otp_load)
		else $error("defaults not taken from otp image");

	property p_run_wr;
		(st_r.ld == BCR_LD_RUN && bus.wr && bus.addr == `BCR_OFF_A_RUN)
		##1 (bus.rd && bus.addr == `BCR_OFF_A_RUN && !bus.wr)
		|=> rd_data == fmask($past(bus.wdata, 2), `BCR_MASK_VCODE);
	endproperty
	a_run_wr: assert property (p_run_wr)
		else $error("run code write not read back");

	property p_rsvd;
		bus.rd && bus.addr == `BCR_OFF_A_CONF
		|=> rd_data[7] == 1'b0 && rd_data[1] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit read as one");

	property p_rd_only_once;
		!bus.rd |=> rd_data == '0;
	endproperty
	a_rd_only_once: assert property (p_rd_only_once)
		else $error("read data outside its cycle");

	property p_mode_wr;
		(st_r.ld == BCR_LD_RUN && bus.wr && bus.addr == `BCR_OFF_B_MODE)
		|=> chan_b.mode == $past(bus.wdata[3:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr)
		else $error("switch mode select not applied");

	property p_b_sleep;
		(st_r.ld == BCR_LD_RUN && st_r.ps == BCR_PS_SLEEP)
		|=> chan_b.vcode == $past(st_r.cfg.b_slp[4:0])
		    && chan_b.on == $past(st_r.cfg.b_mode[5]);
	endproperty
	a_b_sleep: assert property (p_b_sleep)
		else $error("channel b sleep target or off choice wrong");

	property p_a_off;
		st_r.ps == BCR_PS_SLEEP |=> chan_a.on == $past(st_r.cfg.a_mode[5]);
	endproperty
	a_a_off: assert property (p_a_off)
		else $error("channel a off choice ignored");

	property p_a_step;
		(st_r.ld == BCR_LD_RUN && $past(st_r.ld) == BCR_LD_RUN &&
		 st_r.a_v != $past(st_r.a_v))
		|-> (st_r.a_v == 5'($past(st_r.a_v) + 5'h01)) ||
		    (st_r.a_v == 5'($past(st_r.a_v) - 5'h01));
	endproperty
	a_a_step: assert property (p_a_step)
		else $error("channel a moved more than one step");

	property p_a_reach;
		(st_r.ld == BCR_LD_RUN && st_r.a_v != tgt_a)
		|-> ##[1:201] (st_r.a_v != $past(st_r.a_v) || st_r.a_v == tgt_a);
	endproperty
	a_a_reach: assert property (p_a_reach)
		else $error("channel a stalled away from target");

	// Scratch writes go through under main reset as well; only the
	// coin-cell reset may interrupt them.
	property p_scr_wr;
		@(posedge mclk) disable iff (!coin_cell_por_n)
		bus.wr && scr_hit
		|=> scr_r[$past(bus.addr[1:0])] == $past(bus.wdata);
	endproperty
	a_scr_wr: assert property (p_scr_wr)
		else $error("scratch write not stored");

	property p_scr_clr;
		!coin_cell_por_n
		|-> (scr_r[0] | scr_r[1] | scr_r[2] | scr_r[3]) == 8'h00;
	endproperty
	a_scr_clr: assert property (p_scr_clr)
		else $error("scratch not cleared by coin-cell reset");

	property p_b_run;
		(st_r.ld == BCR_LD_RUN && st_r.ps == BCR_PS_RUN)
		|=> chan_b.vcode == $past(st_r.cfg.b_run[`BCR_VCODE_HI:0]);
	endproperty
	a_b_run: assert property (p_b_run)
		else $error("channel b run target wrong");

	property p_b_stby;
		(st_r.ld == BCR_LD_RUN && st_r.ps == BCR_PS_STBY)
		|=> chan_b.vcode == $past(st_r.cfg.b_stby[`BCR_VCODE_HI:0]);
	endproperty
	a_b_stby: assert property (p_b_stby)
		else $error("channel b standby target wrong");

	property p_a_mode_wr;
		(st_r.ld == BCR_LD_RUN && bus.wr && bus.addr == `BCR_OFF_A_MODE)
		|=> chan_a.mode == $past(bus.wdata[`BCR_SMODE_HI:0]) &&
		    st_r.cfg.a_mode[`BCR_OMODE_BIT] ==
		    $past(bus.wdata[`BCR_OMODE_BIT]);
	endproperty
	a_a_mode_wr: assert property (p_a_mode_wr)
		else $error("channel a mode select not applied");

	// Expected fields are cut from the written byte, not from the
	// register copy, so a swapped field map shows up here.
	property p_conf_wr;
		(st_r.ld == BCR_LD_RUN && bus.wr && bus.addr == `BCR_OFF_A_CONF)
		|=> chan_a_conf == {$past(bus.wdata[`BCR_DVS_BIT:`BCR_FREQ_LO]),
		                    $past(bus.wdata[`BCR_ILIM_BIT])};
	endproperty
	a_conf_wr: assert property (p_conf_wr)
		else $error("channel a config fields not applied");

	property p_unmap_wr;
		(st_r.ld == BCR_LD_RUN && bus.wr && bus.addr > `BCR_OFF_B_MODE)
		|=> st_r.cfg == $past(st_r.cfg);
	endproperty
	a_unmap_wr: assert property (p_unmap_wr)
		else $error("write to unmapped address changed a register");

	// A step may only be taken once the period counter has run out.
	property p_a_hold;
		(st_r.ld == BCR_LD_RUN && st_r.a_cnt != 8'h00)
		|=> st_r.a_v == $past(st_r.a_v);
	endproperty
	a_a_hold: assert property (p_a_hold)
		else $error("channel a stepped before its period ran out");

	c_sleep: cover property (st_r.ps == BCR_PS_SLEEP && !chan_a.on);
	c_ramp: cover property (st_r.a_v != tgt_a ##1 st_r.a_v == tgt_a);
	c_wr_rd: cover property (bus.wr ##1 bus.rd);
	c_b_keep_on: cover property (st_r.ps == BCR_PS_SLEEP && chan_b.on);
	c_slow_step: cover property (st_r.cfg.a_conf[`BCR_DVS_BIT] &&
		st_r.a_cnt == 8'h00 && st_r.a_v != tgt_a);

endmodule

/* File: bcr_bank_tb.sv */
// Self-checking bench for the buck configuration and backup register bank.
// Assumes bcr_pkg is compiled first and bcr_regs.svh is on the include path.
`timescale 1ns/1ps
`include "bcr_regs.svh"

module testbench;
	import bcr_pkg::*;

	logic       mclk;
	logic       rst;
	logic       coin_cell_por_n;
	bcr_bus_t   bus;
	logic [7:0] rd_data;
	bcr_cfg_t   otp;
	logic [1:0] pwr_state_in;
	bcr_chan_t  chan_a;
	bcr_chan_t  chan_b;
	bcr_conf_t  chan_a_conf;
	int         n_fail;
	int         tests_run;
	int         gap;

	bcr_bank u_bcr_bank (
		.mclk            (mclk),
		.rst             (rst),
		.coin_cell_por_n (coin_cell_por_n),
		.bus             (bus),
		.rd_data         (rd_data),
		.otp             (otp),
		.pwr_state_in    (pwr_state_in),
		.chan_a          (chan_a),
		.chan_b          (chan_b),
		.chan_a_conf     (chan_a_conf)
	);

	always #10 mclk = ~mclk;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rdchk(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk(what, exp, rd_data);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	function automatic logic [7:0] mask_of(input int i);
		if (i == 3 || i == 8) begin
			return `BCR_MASK_MODE;
		end
		return (i == 4) ? `BCR_MASK_CONF : `BCR_MASK_VCODE;
	endfunction

	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		coin_cell_por_n <= 1'b1;
		settle(2);
	endtask

	task automatic set_ps(input logic [1:0] ps);
		@(posedge mclk);
		pwr_state_in <= ps;
		settle(6);
	endtask

	task automatic wait_a(input string what, input logic [4:0] tgt);
		int k;
		k = 0;
		while (chan_a.vcode !== tgt && k < 8000) begin
			settle(1);
			k++;
		end
		chk(what, {3'h0, tgt}, {3'h0, chan_a.vcode});
	endtask

	// Counts the cycles between two successive steps of channel A.
	task automatic step_gap(output int n);
		logic [4:0] v;
		int k;
		k = 0;
		v = chan_a.vcode;
		while (chan_a.vcode === v && k < 400) begin
			settle(1);
			k++;
		end
		v = chan_a.vcode;
		n = 0;
		while (chan_a.vcode === v && n < 400) begin
			settle(1);
			n++;
		end
	endtask

	task automatic t_defaults();
		for (int i = 0; i < 9; i++) begin
			rdchk("dflt", `BCR_OFF_A_RUN + 8'(i),
				otp[71 - 8 * i -: 8] & mask_of(i));
		end
		chk("a_vc", {3'h0, otp.a_run[4:0]}, {3'h0, chan_a.vcode});
		chk("b_vc", {3'h0, otp.b_run[4:0]}, {3'h0, chan_b.vcode});
		chk("a_md", {4'h0, otp.a_mode[3:0]}, {4'h0, chan_a.mode});
		chk("b_md", {4'h0, otp.b_mode[3:0]}, {4'h0, chan_b.mode});
		chk("a_cf", {2'h0, otp.a_conf[6:2], otp.a_conf[0]},
			{2'h0, chan_a_conf});
	endtask

	task automatic t_fields();
		wr(`BCR_OFF_A_MODE, 8'h2a);
		wr(`BCR_OFF_A_CONF, 8'h3c);
		wr(`BCR_OFF_B_MODE, 8'h09);
		settle(2);
		chk("a_md", 8'h0a, {4'h0, chan_a.mode});
		chk("a_cf", 8'h1e, {2'h0, chan_a_conf});
		chk("b_md", 8'h09, {4'h0, chan_b.mode});
		wr(`BCR_OFF_A_CONF, 8'h41);
		settle(2);
		chk("a_cf", 8'h21, {2'h0, chan_a_conf});
		for (int i = 0; i < 9; i++) begin
			wr(`BCR_OFF_A_RUN + 8'(i), 8'hff);
			rdchk("mask", `BCR_OFF_A_RUN + 8'(i), mask_of(i));
		end
		wr(8'h0d, 8'hff);
		rdchk("unmap", 8'h0d, 8'h00);
		rdchk("unmap", 8'hff, 8'h00);
	endtask

	// Write then read at the next edge, with no idle cycle in between.
	task automatic t_b2b();
		@(posedge mclk);
		bus <= '{addr: `BCR_OFF_SCR_B, wdata: 8'ha5, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '{addr: `BCR_OFF_SCR_B, wdata: 8'ha5, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '{addr: `BCR_OFF_A_RUN, wdata: 8'hf3, wr: 1'b1, rd: 1'b0};
		#1;
		chk("b2b_scr", 8'ha5, rd_data);
		@(posedge mclk);
		bus <= '{addr: `BCR_OFF_A_RUN, wdata: 8'hf3, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk("b2b_run", 8'h13, rd_data);
	endtask

	task automatic t_scratch();
		for (int i = 0; i < 4; i++) begin
			wr(`BCR_OFF_SCR_A + 8'(i), 8'h5a ^ 8'(i * 8'h33));
		end
		otp <= ~otp;
		do_reset();
		for (int i = 0; i < 4; i++) begin
			rdchk("scr", `BCR_OFF_SCR_A + 8'(i),
				8'h5a ^ 8'(i * 8'h33));
		end
		t_defaults();
		@(posedge mclk);
		coin_cell_por_n <= 1'b0;
		settle(2);
		coin_cell_por_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rdchk("scr_clr", `BCR_OFF_SCR_A + 8'(i), 8'h00);
		end
	endtask

	task automatic t_power();
		wr(`BCR_OFF_B_RUN, 8'h03);
		wr(`BCR_OFF_B_STBY, 8'h09);
		wr(`BCR_OFF_B_SLP, 8'h11);
		wr(`BCR_OFF_B_MODE, 8'h25);
		wr(`BCR_OFF_A_MODE, 8'h00);
		set_ps(2'h1);
		chk("b_stby", 8'h09, {3'h0, chan_b.vcode});
		set_ps(2'h2);
		chk("b_slp", 8'h11, {3'h0, chan_b.vcode});
		chk("b_on", 8'h01, {7'h0, chan_b.on});
		chk("a_on", 8'h00, {7'h0, chan_a.on});
		set_ps(2'h3);
		chk("b_slp3", 8'h11, {3'h0, chan_b.vcode});
		rdchk("slp_rd", `BCR_OFF_B_SLP, 8'h11);
		wr(`BCR_OFF_B_MODE, 8'h05);
		wr(`BCR_OFF_A_MODE, 8'h20);
		settle(3);
		chk("b_on", 8'h00, {7'h0, chan_b.on});
		chk("a_on", 8'h01, {7'h0, chan_a.on});
		set_ps(2'h0);
		chk("b_run", 8'h03, {3'h0, chan_b.vcode});
		chk("b_on", 8'h01, {7'h0, chan_b.on});
	endtask

	task automatic t_ramp();
		wr(`BCR_OFF_A_CONF, 8'h00);
		wr(`BCR_OFF_A_RUN, 8'h0a);
		wait_a("a_run", 5'h0a);
		wr(`BCR_OFF_A_RUN, 8'h0d);
		step_gap(gap);
		chk("fast", 8'h64, gap[7:0]);
		wait_a("a_run", 5'h0d);
		wr(`BCR_OFF_A_CONF, 8'h40);
		wr(`BCR_OFF_A_RUN, 8'h10);
		step_gap(gap);
		chk("slow", 8'hc8, gap[7:0]);
		wait_a("a_run", 5'h10);
		wr(`BCR_OFF_A_STBY, 8'h12);
		wr(`BCR_OFF_A_SLP, 8'h0e);
		set_ps(2'h1);
		wait_a("a_stby", 5'h12);
		set_ps(2'h2);
		wait_a("a_slp", 5'h0e);
		set_ps(2'h0);
		wait_a("a_run", 5'h10);
	endtask

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		coin_cell_por_n = 1'b1;
		bus = '0;
		pwr_state_in = 2'h0;
		otp = 72'he4c6a8f3d58369511e;
		n_fail = 0;
		tests_run = 0;
		// Pull the coin-cell reset low after time zero so that the
		// scratch flops see a real falling edge.
		#5;
		coin_cell_por_n = 1'b0;
		do_reset();
		t_defaults();
		t_fields();
		t_b2b();
		t_scratch();
		t_power();
		t_ramp();
		tally_and_finish();
	end

	initial begin
		repeat (40000) @(posedge mclk);
		n_fail++;
		tally_and_finish();
	end
endmodule
